//--- hw/sbd_pkg.sv
// Package: opcodes, flag positions, reset values and sizes for the subtract/decrement datapath
package sbd_pkg;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned ADDR_W      = 7;
   localparam int unsigned MEM_DEPTH   = 128;
   localparam int unsigned SKIP_CYCLES = 2;
   // Flag positions in the flags byte
   localparam int unsigned FLAG_CARRY  = 0;
   localparam int unsigned FLAG_NIBBLE = 1;
   localparam int unsigned FLAG_ZERO   = 2;
   localparam int unsigned FLAG_RANGE  = 3;
   localparam int unsigned FLAG_W      = 4;
   localparam logic [3:0]  FLAGS_RST   = 4'h0;
   localparam logic [7:0]  WORK_RST    = 8'h00;
   localparam logic [7:0]  MEM_RST     = 8'h00;
   typedef enum logic [1:0] {
      OP_NONE,
      OP_SUB_TO_WORKING,
      OP_SUB_TO_MEMORY,
      OP_DEC_SKIP
   } op_t;
   typedef enum {
      ST_IDLE,
      ST_READ,
      ST_EXEC,
      ST_DUMMY
   } state_t;
endpackage

//--- hw/sbd_data_mem.sv
// Data memory: synchronous write, registered read data
module sbd_data_mem
   import sbd_pkg::*;
#(
   parameter int unsigned WIDTH = DATA_W,
   parameter int unsigned DEPTH = MEM_DEPTH,
   parameter int unsigned AW    = ADDR_W
) (
   input  wire logic             i_ref_clk,
   input  wire logic [AW-1:0]    i_addr,
   input  wire logic             i_we,
   input  wire logic [WIDTH-1:0] i_wdata,
   input  wire logic [AW-1:0]    i_raddr,
   output logic      [WIDTH-1:0] o_rdata
);
   initial begin
      if (DEPTH > (1 << AW)) $error("sbd_data_mem: depth exceeds address range");
   end

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge i_ref_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule // sbd_data_mem

//--- hw/sbd_sub_unit.sv
// Subtract unit: a - b - borrow with all four flags
module sbd_sub_unit
   import sbd_pkg::*;
(
   input  wire logic [7:0] i_a,
   input  wire logic [7:0] i_b,
   input  wire logic       i_carry,
   output logic      [7:0] o_diff,
   output logic      [3:0] o_flags
);
   logic [8:0] full;
   logic [4:0] low;
   logic       borrow_in;

   // Carry 1 means no borrow pending
   assign borrow_in = ~i_carry;
   assign full      = {1'b0, i_a} - {1'b0, i_b} - {8'h00, borrow_in};
   assign low       = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, borrow_in};
   assign o_diff    = full[7:0];
   assign o_flags[FLAG_CARRY]  = ~full[8];
   assign o_flags[FLAG_NIBBLE] = ~low[4];
   assign o_flags[FLAG_ZERO]   = (full[7:0] == 8'h00);
   assign o_flags[FLAG_RANGE]  = (i_a[7] ^ i_b[7]) & (i_a[7] ^ full[7]);
endmodule // sbd_sub_unit

//--- hw/sbd_core.sv
// Top: executes subtract-with-borrow and decrement-skip instructions on working reg and memory
//
// Notes on behaviour
// - Subtract to working takes memory byte and inverse carry from working and keeps it there.
// - After either subtract the carry reads 0 on a negative difference and 1 otherwise.
// - Subtract to memory does the same sum, stores it in memory and updates all four flags.
// - Decrement-skip lowers the memory byte by one and skips the next instruction on zero.
// - A skip takes two cycles, the second a dummy in ST_DUMMY during which starts are dropped.
// - A nonzero decrement result proceeds with the next instruction, no skip.
module sbd_core
   import sbd_pkg::*;
#(
   parameter int unsigned AW = ADDR_W
) (
   // Clock and reset
   input  wire logic          i_ref_clk,
   input  wire logic          i_rst,
   // Instruction issue
   input  wire logic          i_start,
   input  wire op_t           i_op,
   input  wire logic [AW-1:0] i_addr,
   // Memory preload port, used while idle
   input  wire logic          i_load_we,
   input  wire logic [AW-1:0] i_load_addr,
   input  wire logic [7:0]    i_load_data,
   // Register bus
   input  wire logic [1:0]    i_reg_addr,
   input  wire logic [7:0]    i_reg_wdata,
   input  wire logic          i_reg_wr,
   input  wire logic          i_reg_rd,
   output logic      [7:0]    o_reg_rdata,
   // State
   output logic      [7:0]    o_working_register,
   output logic      [3:0]    o_flags,
   output logic               o_busy,
   output logic               o_done,
   output logic               o_skip
);
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [1:0] REG_WORK  = 2'h0;
   localparam logic [1:0] REG_FLAGS = 2'h1;
   localparam logic [1:0] REG_STAT  = 2'h2;

   initial begin
      if (AW != ADDR_W) $error("sbd_core: address width must match memory");
   end

   state_t        state_r, state_nxt;
   op_t           op_r;
   logic [AW-1:0] addr_r;
   logic [7:0]    work_r, mem_rdata, diff, dec_val;
   logic [3:0]    flags_r, sub_flags;
   logic          done_r, skip_r;
   logic [7:0]    rdata_r;
   logic          exec, is_sub, is_dec, dec_zero, mem_we;
   logic [AW-1:0] mem_waddr;
   logic [7:0]    mem_wdata;

   sbd_data_mem #(.WIDTH(DATA_W), .DEPTH(MEM_DEPTH), .AW(AW)) u_mem (
      .i_ref_clk (i_ref_clk),
      .i_addr    (mem_waddr),
      .i_we      (mem_we),
      .i_wdata   (mem_wdata),
      .i_raddr   (addr_r),
      .o_rdata   (mem_rdata)
   );

   sbd_sub_unit u_sub (
      .i_a     (work_r),
      .i_b     (mem_rdata),
      .i_carry (flags_r[FLAG_CARRY]),
      .o_diff  (diff),
      .o_flags (sub_flags)
   );

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   assign exec      = (state_r == ST_EXEC);
   assign is_sub    = (op_r == OP_SUB_TO_WORKING) || (op_r == OP_SUB_TO_MEMORY);
   assign is_dec    = (op_r == OP_DEC_SKIP);
   assign dec_val   = mem_rdata - 8'h01;
   assign dec_zero  = (dec_val == 8'h00);
   // Writes from the datapath win; the load port is only for idle preloading
   assign mem_we    = (exec && (op_r == OP_SUB_TO_MEMORY || is_dec))
                      || (state_r == ST_IDLE && i_load_we);
   assign mem_waddr = exec ? addr_r : i_load_addr;
   assign mem_wdata = !exec ? i_load_data
                    : (is_dec ? dec_val : diff);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:  if (i_start && i_op != OP_NONE) state_nxt = ST_READ;
         ST_READ:  state_nxt = ST_EXEC;
         ST_EXEC:  state_nxt = (is_dec && dec_zero) ? ST_DUMMY : ST_IDLE;
         ST_DUMMY: state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // State and datapath registers
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
         op_r    <= OP_NONE;
         addr_r  <= '0;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_IDLE && i_start) begin
            op_r   <= i_op;
            addr_r <= i_addr;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         work_r  <= WORK_RST;
         flags_r <= FLAGS_RST;
      end else if (exec && is_sub) begin
         flags_r <= sub_flags;
         if (op_r == OP_SUB_TO_WORKING) begin
            work_r <= diff;
         end
      end else if (state_r == ST_IDLE && i_reg_wr) begin
         if (i_reg_addr == REG_WORK)  work_r  <= i_reg_wdata;
         if (i_reg_addr == REG_FLAGS) flags_r <= i_reg_wdata[3:0];
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         done_r <= 1'b0;
         skip_r <= 1'b0;
      end else begin
         done_r <= (exec && !(is_dec && dec_zero)) || (state_r == ST_DUMMY);
         skip_r <= exec && is_dec && dec_zero;
      end
   end

   logic [7:0] rd_mux;
   assign rd_mux = (i_reg_addr == REG_WORK)  ? work_r
                 : (i_reg_addr == REG_FLAGS) ? {4'h0, flags_r}
                 : (i_reg_addr == REG_STAT)  ? {6'h00, skip_r, (state_r != ST_IDLE)}
                 : 8'h00;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) rdata_r <= 8'h00;
      else       rdata_r <= i_reg_rd ? rd_mux : 8'h00;
   end

   logic busy_r;
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) busy_r <= 1'b0;
      else       busy_r <= (state_nxt != ST_IDLE);
   end

   assign o_reg_rdata        = rdata_r;
   assign o_working_register = work_r;
   assign o_flags            = flags_r;
   assign o_busy             = busy_r;
   assign o_done             = done_r;
   assign o_skip             = skip_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_dec_zero;
      exec && is_dec && dec_zero;
   endsequence

   a_skip_two_cycles: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_dec_zero |=> (state_r == ST_DUMMY) ##1 (state_r == ST_IDLE && done_r))
      else $error("skip did not take a dummy cycle");
   a_no_skip_nonzero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (exec && is_dec && !dec_zero) |=> (!skip_r && done_r && state_r == ST_IDLE))
      else $error("nonzero decrement skipped");
   a_dec_flags_kept: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (exec && is_dec) |=> $stable(flags_r))
      else $error("decrement changed flags");
   a_dec_writeback: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (exec && is_dec) |-> (mem_we && mem_wdata == mem_rdata - 8'h01))
      else $error("decrement not written back");
   a_sub_working: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (exec && op_r == OP_SUB_TO_WORKING)
      |=> work_r == $past(work_r) - $past(mem_rdata) - {7'h00, ~$past(flags_r[FLAG_CARRY])})
      else $error("subtract to working wrong");
   a_carry_sign: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (exec && is_sub) |=> flags_r[FLAG_CARRY]
         == ({1'b0, $past(work_r)} >= {1'b0, $past(mem_rdata)}
             + {8'h00, ~$past(flags_r[FLAG_CARRY])}))
      else $error("carry does not follow sign");
   a_sub_memory: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (exec && op_r == OP_SUB_TO_MEMORY) |-> (mem_we && mem_wdata == diff)
         ##1 ($stable(work_r) && flags_r == $past(sub_flags)))
      else $error("subtract to memory wrong");
   a_zero_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (exec && is_sub) |=> flags_r[FLAG_ZERO] == ($past(diff) == 8'h00))
      else $error("zero flag wrong");

   // ------------------------------------------------------------
   // Sequencing and flag checks
   // ------------------------------------------------------------
   // A start is only taken from idle; later starts are dropped silently
   sequence s_start_taken;
      state_r == ST_IDLE && i_start && i_op != OP_NONE;
   endsequence

   sequence s_read_then_exec;
      (state_r == ST_READ) ##1 exec;
   endsequence

   sequence s_sub_exec;
      exec && is_sub;
   endsequence

   sequence s_dec_nonzero;
      exec && is_dec && !dec_zero;
   endsequence

   a_start_to_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_start_taken |=> s_read_then_exec)
      else $error("start did not walk read then execute");

   a_busy_follows: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_start_taken |=> busy_r)
      else $error("busy not raised after start");

   a_start_ignored: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_r != ST_IDLE && i_start) |=> $stable(op_r))
      else $error("start accepted while busy");

   a_done_single: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      done_r |=> !done_r)
      else $error("done longer than one cycle");

   a_skip_single: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      skip_r |=> !skip_r)
      else $error("skip longer than one cycle");

   a_skip_only_dec: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      skip_r |-> ($past(state_r) == ST_EXEC && $past(op_r) == OP_DEC_SKIP))
      else $error("skip raised outside a decrement");

   a_dec_zero_skip: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_dec_zero |=> skip_r && !done_r)
      else $error("zero decrement did not skip");

   a_dec_nonzero_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_dec_nonzero |=> !busy_r)
      else $error("nonzero decrement held the core");

   a_sub_no_skip: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_sub_exec |=> !skip_r && done_r)
      else $error("subtract raised skip");

   a_dummy_to_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_r == ST_DUMMY) |=> (state_r == ST_IDLE && !busy_r))
      else $error("dummy cycle did not end");

   a_dec_work_kept: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (exec && is_dec) |=> $stable(work_r))
      else $error("decrement changed working register");

   // Nibble flag worked out from the operands, not from the subtract unit
   a_nibble_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_sub_exec |=> flags_r[FLAG_NIBBLE]
         == ({1'b0, $past(work_r[3:0])} >= {1'b0, $past(mem_rdata[3:0])}
             + {4'h0, ~$past(flags_r[FLAG_CARRY])}))
      else $error("nibble flag wrong");

   // Signed range: operands of unlike sign and a result whose sign left the minuend
   a_range_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_sub_exec |=> flags_r[FLAG_RANGE]
         == (($past(work_r[7]) ^ $past(mem_rdata[7])) & ($past(work_r[7]) ^ $past(diff[7]))))
      else $error("signed range flag wrong");

   // The preload port must never reach memory while an instruction runs
   a_load_idle_only: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (mem_we && !exec) |-> (state_r == ST_IDLE && i_load_we))
      else $error("memory written outside execute or idle load");

   a_rdata_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_reg_rd |=> (rdata_r == 8'h00))
      else $error("read data without a read strobe");
endmodule // sbd_core

//--- tb/tb_sbd_core.sv
// Self-checking bench for the subtract-with-borrow and decrement-skip datapath
module tb_sbd_core;
   timeunit 1ns;
   timeprecision 1ps;
   import sbd_pkg::*;
   `define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_total++; \
      $display("unexpected %s: expected %h, seen %h", nm, ex, gt); end end
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic       i_ref_clk, i_rst, i_start, i_load_we, i_reg_wr, i_reg_rd;
   op_t        i_op;
   logic [6:0] i_addr, i_load_addr;
   logic [7:0] i_load_data, i_reg_wdata, o_reg_rdata, o_working_register;
   logic [1:0] i_reg_addr;
   logic [3:0] o_flags;
   logic       o_busy, o_done, o_skip;
   int         err_total, tests_run, cyc, seed;
   sbd_core uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_start(i_start), .i_op(i_op),
      .i_addr(i_addr), .i_load_we(i_load_we), .i_load_addr(i_load_addr),
      .i_load_data(i_load_data), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
      .o_working_register(o_working_register), .o_flags(o_flags), .o_busy(o_busy),
      .o_done(o_done), .o_skip(o_skip));
   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end
   // Hang guard: a full run needs well under 10000 cycles
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_reg_wr <= 1'b1; i_reg_addr <= a; i_reg_wdata <= d;
      @(posedge i_ref_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rreg(input logic [1:0] a, output logic [7:0] d);
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b1; i_reg_addr <= a;
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b0;
      #1 d = o_reg_rdata;
   endtask
   task automatic load(input logic [6:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_load_we <= 1'b1; i_load_addr <= a; i_load_data <= d;
      @(posedge i_ref_clk);
      i_load_we <= 1'b0;
   endtask
   // Counts edges after the one that samples the start, up to the done pulse
   task automatic run_op(input op_t op, input logic [6:0] a, output logic sk, output int n);
      @(posedge i_ref_clk);
      i_start <= 1'b1; i_op <= op; i_addr <= a;
      @(posedge i_ref_clk);
      i_start <= 1'b0;
      n = 0; sk = 1'b0;
      do begin
         @(posedge i_ref_clk);
         n++;
         #1 if (o_skip === 1'b1) sk = 1'b1;
         if (n == 1) `CHK("busy", 1'b1, o_busy)
      end while (o_done !== 1'b1 && n < 8);
      `CHK("busy at done", 1'b0, o_busy)
   endtask
   // Returns {range, zero, nibble, carry, difference}
   function automatic logic [11:0] exp_sub(logic [7:0] a, logic [7:0] b, logic c);
      logic [8:0] f;
      logic [4:0] h;
      f = {1'b0, a} - {1'b0, b} - {8'h00, ~c};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~c};
      return {(a[7] ^ b[7]) & (f[7] ^ a[7]), f[7:0] == 8'h00, ~h[4], ~f[8], f[7:0]};
   endfunction
   // Memory has no read port: recover it as the negation 0 - m with no borrow
   task automatic peek(input logic [6:0] a, input logic [7:0] ex);
      logic sk;
      int   n;
      wreg(2'h0, 8'h00);
      wreg(2'h1, 8'h01);
      run_op(OP_SUB_TO_WORKING, a, sk, n);
      `CHK("memory", 8'h00 - ex, o_working_register)
   endtask
   task automatic do_case(input op_t op, input logic [7:0] a, input logic [7:0] m,
                          input logic [3:0] fl, input logic [6:0] ad);
      logic [11:0] r;
      logic [7:0]  v;
      logic        sk;
      int          n;
      load(ad, m);
      wreg(2'h0, a);
      wreg(2'h1, {4'h0, fl});
      run_op(op, ad, sk, n);
      r = exp_sub(a, m, fl[0]);
      if (op == OP_DEC_SKIP) begin
         `CHK("skip", m == 8'h01, sk)
         `CHK("latency", (m == 8'h01) ? 3 : 2, n)
         `CHK("dec flags", fl, o_flags)
         `CHK("dec working", a, o_working_register)
         peek(ad, m - 8'h01);
      end else begin
         `CHK("sub skip", 1'b0, sk)
         `CHK("sub latency", 2, n)
         `CHK("flags", r[11:8], o_flags)
         rreg(2'h1, v);
         `CHK("flags reg", {4'h0, r[11:8]}, v)
         if (op == OP_SUB_TO_WORKING) `CHK("working", r[7:0], o_working_register)
         else begin
            `CHK("working kept", a, o_working_register)
            peek(ad, r[7:0]);
         end
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] v;
      err_total = 0; tests_run = 0; cyc = 0; seed = 32'h75c0;
      i_rst = 1'b1; i_start = 1'b0; i_op = OP_NONE; i_addr = 7'h00;
      i_load_we = 1'b0; i_load_addr = 7'h00; i_load_data = 8'h00;
      i_reg_addr = 2'h0; i_reg_wdata = 8'h00; i_reg_wr = 1'b0; i_reg_rd = 1'b0;
      repeat (6) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      #1 `CHK("reset working", WORK_RST, o_working_register)
      `CHK("reset flags", FLAGS_RST, o_flags)
      rreg(2'h3, v);
      `CHK("unmapped read", 8'h00, v)
      // Borrow edges, signed overflow, zero result, nibble borrow
      do_case(OP_SUB_TO_WORKING, 8'h80, 8'h01, 4'h1, 7'h05);
      do_case(OP_SUB_TO_WORKING, 8'h10, 8'h0f, 4'h0, 7'h7f);
      do_case(OP_SUB_TO_WORKING, 8'h00, 8'h00, 4'h0, 7'h00);
      do_case(OP_SUB_TO_MEMORY, 8'h7f, 8'hff, 4'h1, 7'h11);
      do_case(OP_SUB_TO_MEMORY, 8'h05, 8'h05, 4'h1, 7'h12);
      do_case(OP_DEC_SKIP, 8'h3c, 8'h01, 4'hf, 7'h20);
      do_case(OP_DEC_SKIP, 8'hc3, 8'h00, 4'ha, 7'h21);
      do_case(OP_DEC_SKIP, 8'h00, 8'h02, 4'h5, 7'h22);
      rreg(2'h2, v);
      `CHK("status idle", 8'h00, v)
      $display("corner cases done");
      for (int k = 0; k < 60; k++) begin
         do_case(op_t'(2'({$random(seed)} % 3 + 1)),
                 8'($random(seed)), (k % 4 == 0) ? 8'h01 : 8'($random(seed)),
                 4'($random(seed)), 7'($random(seed)));
      end
      $display("random cases done");
      wrap_up();
   end
endmodule // tb_sbd_core
